// ### verilog/pig_top.sv
// port integration block: registers of ports A, C, D behind an APB slave
`timescale 1ns/1ns
module pig_top #(
  parameter int PA_W = pig_pkg::PIG_PA_W,
  parameter int PC_W = pig_pkg::PIG_PC_W,
  parameter int PD_W = pig_pkg::PIG_PD_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pig_pkg::PIG_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PA_W-1:0] pa_in,
  output logic [PA_W-1:0] pa_out,
  output logic [PA_W-1:0] pa_oe,
  input wire logic [PC_W-1:0] pc_in,
  output logic [PC_W-1:0] pc_out,
  output logic [PC_W-1:0] pc_oe,
  input wire logic [PD_W-1:0] pd_in,
  output logic [PD_W-1:0] pd_out,
  output logic [PD_W-1:0] pd_oe,
  input wire logic [PA_W-1:0] spi_own,
  input wire logic [PA_W-1:0] spi_out,
  input wire logic [PA_W-1:0] spi_oe,
  output logic [PA_W-1:0] spi_in,
  input wire logic inter_die_clock_line_out,
  input wire logic inter_die_clock_line_oe,
  input wire logic inter_die_interrupt_line_out,
  input wire logic inter_die_interrupt_line_oe,
  input wire logic [PD_W-1:0] inter_die_data_line_out,
  input wire logic [PD_W-1:0] inter_die_data_line_oe,
  output logic [PD_W-1:0] inter_die_data_line_in,
  output logic inter_die_interrupt_line_in,
  output logic inter_die_clock_line_in
);
  import pig_pkg::*;

  logic [PA_W-1:0] pa_data_ff;
  logic [PA_W-1:0] port_a_direction_ff;
  logic [PC_W-1:0] port_c_data_ff;
  logic [PC_W-1:0] port_c_direction_ff;
  logic [PD_W-1:0] port_d_data_ff;
  logic [PD_W-1:0] port_d_direction_ff;
  logic [1:0] idi_ctrl_ff;
  logic [31:0] prdata_ff;

  logic [PA_W-1:0] pa_sync;
  logic [PC_W-1:0] pc_sync;
  logic [PD_W-1:0] pd_sync;
  logic [PA_W-1:0] pa_rd;
  logic [PC_W-1:0] pc_rd;
  logic [PD_W-1:0] pd_rd;

  pig_sync #(.W(PA_W)) u_sync_a (.pclk(pclk), .presetn(presetn), .d(pa_in), .q(pa_sync));
  pig_sync #(.W(PC_W)) u_sync_c (.pclk(pclk), .presetn(presetn), .d(pc_in), .q(pc_sync));
  pig_sync #(.W(PD_W)) u_sync_d (.pclk(pclk), .presetn(presetn), .d(pd_in), .q(pd_sync));

  // inter-die link mode from the control word
  wire idi_en = idi_ctrl_ff[PIG_CTRL_EN_BIT];
  wire idi_byte = idi_ctrl_ff[PIG_CTRL_W8_BIT];
  pig_mode_e idi_mode;
  assign idi_mode = !idi_en ? PIG_IDI_OFF : (idi_byte ? PIG_IDI_BYTE : PIG_IDI_NIB);

  // ownership masks for port C and port D
  wire [PC_W-1:0] pc_own = {PC_W{idi_mode != PIG_IDI_OFF}};
  wire [PD_W-1:0] nib_mask = PD_W'((1 << PIG_PD_NIB) - 1);
  wire [PD_W-1:0] pd_own = (idi_mode == PIG_IDI_BYTE) ? {PD_W{1'b1}} :
                           (idi_mode == PIG_IDI_NIB) ? nib_mask : '0;

  logic [PC_W-1:0] pc_alt_out;
  logic [PC_W-1:0] pc_alt_oe;
  always_comb begin
    pc_alt_out = '0;
    pc_alt_oe = '0;
    pc_alt_out[PIG_PC_INT_BIT] = inter_die_interrupt_line_out;
    pc_alt_oe[PIG_PC_INT_BIT] = inter_die_interrupt_line_oe;
    pc_alt_out[PIG_PC_CLK_BIT] = inter_die_clock_line_out;
    pc_alt_oe[PIG_PC_CLK_BIT] = inter_die_clock_line_oe;
  end

  pig_pin #(.W(PA_W)) u_pin_a (
    .port_data(pa_data_ff),
    .port_dir(port_a_direction_ff),
    .alt_own(spi_own),
    .alt_out(spi_out),
    .alt_oe(spi_oe),
    .pin_sync(pa_sync),
    .pin_out(pa_out),
    .pin_oe(pa_oe),
    .rd_val(pa_rd)
  );
  pig_pin #(.W(PC_W)) u_pin_c (
    .port_data(port_c_data_ff),
    .port_dir(port_c_direction_ff),
    .alt_own(pc_own),
    .alt_out(pc_alt_out),
    .alt_oe(pc_alt_oe),
    .pin_sync(pc_sync),
    .pin_out(pc_out),
    .pin_oe(pc_oe),
    .rd_val(pc_rd)
  );
  pig_pin #(.W(PD_W)) u_pin_d (
    .port_data(port_d_data_ff),
    .port_dir(port_d_direction_ff),
    .alt_own(pd_own),
    .alt_out(inter_die_data_line_out),
    .alt_oe(inter_die_data_line_oe),
    .pin_sync(pd_sync),
    .pin_out(pd_out),
    .pin_oe(pd_oe),
    .rd_val(pd_rd)
  );

  // peripherals see the synchronised pin levels
  assign spi_in = pa_sync;
  assign inter_die_data_line_in = pd_sync;
  assign inter_die_interrupt_line_in = pc_sync[PIG_PC_INT_BIT];
  assign inter_die_clock_line_in = pc_sync[PIG_PC_CLK_BIT];

  // apb decode: zero-wait slave, unmapped offsets answer with pslverr
  wire access = psel && penable;
  wire wr_en = access && pwrite && pstrb[0];
  wire hit_pa = (paddr == PIG_OFS_PTA_DATA);
  wire hit_rsvd_a = (paddr == PIG_OFS_RSVD_A);
  wire hit_pa_dir = (paddr == PIG_OFS_PA_DIR);
  wire hit_rsvd_b = (paddr == PIG_OFS_RSVD_B);
  wire hit_pc = (paddr == PIG_OFS_PC_DATA);
  wire hit_pd = (paddr == PIG_OFS_PD_DATA);
  wire hit_pc_dir = (paddr == PIG_OFS_PC_DIR);
  wire hit_pd_dir = (paddr == PIG_OFS_PD_DIR);
  wire hit_ctrl = (paddr == PIG_OFS_IDI_CTRL);
  wire mapped = hit_pa || hit_rsvd_a || hit_pa_dir || hit_rsvd_b || hit_pc || hit_pd
                || hit_pc_dir || hit_pd_dir || hit_ctrl;

  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_ff;

  // reserved words decode to zero and have no write path
  wire [31:0] rd_mux = hit_pa ? 32'(pa_rd) :
                       hit_pa_dir ? 32'(port_a_direction_ff) :
                       hit_pc ? 32'(pc_rd) :
                       hit_pd ? 32'(pd_rd) :
                       hit_pc_dir ? 32'(port_c_direction_ff) :
                       hit_pd_dir ? 32'(port_d_direction_ff) :
                       hit_ctrl ? 32'(idi_ctrl_ff) : 32'h0000_0000;

  // read data registered at the setup phase, valid through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_data_ff <= PIG_RST_VAL[PA_W-1:0];
      port_a_direction_ff <= PIG_RST_VAL[PA_W-1:0];
      port_c_data_ff <= PIG_RST_VAL[PC_W-1:0];
      port_c_direction_ff <= PIG_RST_VAL[PC_W-1:0];
      port_d_data_ff <= PIG_RST_VAL[PD_W-1:0];
      port_d_direction_ff <= PIG_RST_VAL[PD_W-1:0];
      idi_ctrl_ff <= 2'b00;
    end else if (wr_en) begin
      if (hit_pa) pa_data_ff <= pwdata[PA_W-1:0];
      if (hit_pa_dir) port_a_direction_ff <= pwdata[PA_W-1:0];
      if (hit_pc) port_c_data_ff <= pwdata[PC_W-1:0];
      if (hit_pd) port_d_data_ff <= pwdata[PD_W-1:0];
      if (hit_pc_dir) port_c_direction_ff <= pwdata[PC_W-1:0];
      if (hit_pd_dir) port_d_direction_ff <= pwdata[PD_W-1:0];
      if (hit_ctrl) idi_ctrl_ff <= pwdata[1:0];
    end
  end
endmodule

// ### verilog/pig_pkg.sv
// package: register map, field widths and reset values of the port block
package pig_pkg;
  localparam int PIG_AW = 12;
  // register indices; each register sits in its own word, so the bus address is index times four
  localparam logic [11:0] PIG_IDX_PA_DATA = 12'h000;
  localparam logic [11:0] PIG_IDX_RSVD_A = 12'h001;
  localparam logic [11:0] PIG_IDX_PA_DIR = 12'h002;
  localparam logic [11:0] PIG_IDX_RSVD_B = 12'h003;
  localparam logic [11:0] PIG_IDX_PC_DATA = 12'h004;
  localparam logic [11:0] PIG_IDX_PD_DATA = 12'h005;
  localparam logic [11:0] PIG_IDX_PC_DIR = 12'h006;
  localparam logic [11:0] PIG_IDX_PD_DIR = 12'h007;
  localparam logic [11:0] PIG_OFS_PTA_DATA = PIG_IDX_PA_DATA << 2;
  localparam logic [11:0] PIG_OFS_RSVD_A = PIG_IDX_RSVD_A << 2;
  localparam logic [11:0] PIG_OFS_PA_DIR = PIG_IDX_PA_DIR << 2;
  localparam logic [11:0] PIG_OFS_RSVD_B = PIG_IDX_RSVD_B << 2;
  localparam logic [11:0] PIG_OFS_PC_DATA = PIG_IDX_PC_DATA << 2;
  localparam logic [11:0] PIG_OFS_PD_DATA = PIG_IDX_PD_DATA << 2;
  localparam logic [11:0] PIG_OFS_PC_DIR = PIG_IDX_PC_DIR << 2;
  localparam logic [11:0] PIG_OFS_PD_DIR = PIG_IDX_PD_DIR << 2;
  localparam logic [11:0] PIG_OFS_IDI_CTRL = 12'h080;
  localparam int PIG_PA_W = 6;
  localparam int PIG_PC_W = 2;
  localparam int PIG_PD_W = 8;
  localparam int PIG_PD_NIB = 4;
  localparam int PIG_PC_INT_BIT = 1;
  localparam int PIG_PC_CLK_BIT = 0;
  localparam int PIG_CTRL_EN_BIT = 0;
  localparam int PIG_CTRL_W8_BIT = 1;
  localparam logic [7:0] PIG_RST_VAL = 8'h00;
  typedef enum logic [1:0] {
    PIG_IDI_OFF = 2'b00,
    PIG_IDI_NIB = 2'b01,
    PIG_IDI_BYTE = 2'b11
  } pig_mode_e;
endpackage

// ### verilog/pig_sync.sv
// two-stage synchroniser for a bus of pin inputs
`timescale 1ns/1ns
module pig_sync #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule

// ### verilog/pig_pin.sv
// one general-purpose port: pin mux between port registers and alternate function
`timescale 1ns/1ns
module pig_pin #(
  parameter int W = 8
) (
  input wire logic [W-1:0] port_data,
  input wire logic [W-1:0] port_dir,
  input wire logic [W-1:0] alt_own,
  input wire logic [W-1:0] alt_out,
  input wire logic [W-1:0] alt_oe,
  input wire logic [W-1:0] pin_sync,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe,
  output logic [W-1:0] rd_val
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // alternate function takes the pin, stored direction left untouched
      assign pin_out[i] = alt_own[i] ? alt_out[i] : port_data[i];
      assign pin_oe[i] = alt_own[i] ? alt_oe[i] : port_dir[i];
      assign rd_val[i] = port_dir[i] ? port_data[i] : pin_sync[i];
    end
  endgenerate
endmodule

// ### test/pig_far.sv
// far side of the pins: each line follows its driver, else the outside level
`timescale 1ns/1ns
module pig_far (
  input logic [15:0] drv,
  input logic [15:0] oe,
  input logic [15:0] ext,
  output logic [15:0] lvl
);
  // an undriven pin shows the outside level, never the last driven value
  assign lvl = (oe & drv) | (~oe & ext);
endmodule

// ### test/pig_top_asserts.sv
// checker: assertions on the port block pins and register bus
`timescale 1ns/1ns
module pig_chk (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  input logic pslverr,
  input logic [5:0] pa_oe,
  input logic [5:0] spi_own,
  input logic [5:0] spi_oe,
  input logic [1:0] pc_oe,
  input logic [7:0] pd_oe,
  input logic inter_die_clock_line_oe,
  input logic inter_die_interrupt_line_oe,
  input logic [7:0] inter_die_data_line_oe
);
  logic [1:0] mode_ff;
  // shadow of the link control word, seen only through bus writes
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) mode_ff <= 2'h0;
    else if (psel && penable && pwrite && pstrb[0] && paddr == 12'h080) mode_ff <= pwdata[1:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_spi_dir:
    assert property (((pa_oe ^ spi_oe) & spi_own) == 6'h00) else $error("spi dir ignored");
  a_rsvd_read:
    assert property (psel && !penable && !pwrite && paddr == 12'h004 |=> prdata == 32'h0)
      else $error("reserved word not zero");
  a_rsvd_quiet:
    assert property (psel && penable && paddr == 12'h004 |-> !pslverr) else $error("reserved err");
  a_pc_upper:
    assert property (psel && !penable && !pwrite && paddr == 12'h010 |=> prdata[31:2] == 30'h0)
      else $error("port c upper bits set");
  a_reset_idle:
    assert property ($rose(presetn) |-> pc_oe == 2'h0 && pd_oe == 8'h00) else $error("oe after reset");
  a_link_pins:
    assert property (mode_ff[0] |-> pc_oe == {inter_die_interrupt_line_oe, inter_die_clock_line_oe})
      else $error("link does not own port c");
  a_link_byte:
    assert property (mode_ff == 2'h3 |-> pd_oe == inter_die_data_line_oe) else $error("byte mode");
  a_link_nib:
    assert property (mode_ff == 2'h1 |-> pd_oe[3:0] == inter_die_data_line_oe[3:0])
      else $error("nibble mode");
endmodule
bind pig_top pig_chk u_chk (.*);

// ### test/test_port_integration_gpio.sv
// testbench: port block driven over the register bus with pins modelled
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module test_port_integration_gpio;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [5:0] pa_out, pa_oe, spi_own = 0, spi_oe = 0;
  logic [1:0] pc_out, pc_oe;
  logic [7:0] pd_out, pd_oe, d_oe = 0, d_out = 0, idi_in;
  logic [5:0] s_out = 0, spi_in;
  logic err = 0, int_in, clk_in;
  logic [15:0] ext = 0;
  logic [3:0] lk = 0;
  wire [5:0] pa_in;
  wire [1:0] pc_in;
  wire [7:0] pd_in;
  int error_cnt = 0, checked = 0;
  always #20 pclk = ~pclk;
  pig_far u_far (.drv({pa_out, pc_out, pd_out}), .oe({pa_oe, pc_oe, pd_oe}), .ext(ext),
    .lvl({pa_in, pc_in, pd_in}));
  pig_top DUT (.*, .pstrb(4'hF), .spi_out(s_out), .spi_in(spi_in),
    .inter_die_data_line_out(d_out),
    .inter_die_clock_line_out(lk[0]), .inter_die_clock_line_oe(lk[1]),
    .inter_die_interrupt_line_out(lk[2]), .inter_die_interrupt_line_oe(lk[3]),
    .inter_die_data_line_oe(d_oe), .inter_die_data_line_in(idi_in),
    .inter_die_interrupt_line_in(int_in), .inter_die_clock_line_in(clk_in));
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // pins are looked at mid-cycle, once the access edge has landed
  task automatic settle;
    @(negedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1, a, {24'h0, d}, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(0, a, 32'h0, r);
    `CHK(r, e)
  endtask
  task automatic test_done;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #40000;
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rd(12'h008, 32'h0);
    rd(12'h018, 32'h0);
    rd(12'h01C, 32'h0);
    rd(12'h010, 32'h0);
    $display("test reset done");
    wr(12'h008, 8'hFF);
    rd(12'h008, 32'h3F);
    s_out <= 6'h2A;
    wr(12'h000, 8'h15);
    settle;
    `CHK(pa_oe, 6'h3F)
    `CHK(pa_out, 6'h15)
    @(posedge pclk);
    spi_own <= 6'h0F;
    settle;
    `CHK(pa_oe, 6'h30)
    `CHK(pa_out, 6'h1A)
    rd(12'h008, 32'h3F);
    settle;
    `CHK(spi_in, 6'h10)
    wr(12'h004, 8'hFF);
    rd(12'h004, 32'h0);
    `CHK(err, 1'b0)
    rd(12'h008, 32'h3F);
    rd(12'h040, 32'h0);
    `CHK(err, 1'b1)
    wr(12'h018, 8'h03);
    wr(12'h010, 8'hFF);
    rd(12'h010, 32'h03);
    settle;
    `CHK(pc_out, 2'h3)
    $display("test port a and reserved done");
    wr(12'h01C, 8'h0F);
    wr(12'h014, 8'hA5);
    ext <= 16'h003C;
    repeat (3) @(posedge pclk);
    rd(12'h014, 32'h35);
    settle;
    `CHK(pd_out[3:0], 4'h5)
    @(posedge pclk);
    d_oe <= 8'hF0;
    d_out <= 8'hC3;
    lk <= 4'h3;
    wr(12'h080, 8'h01);
    settle;
    `CHK(pd_oe, 8'h00)
    `CHK(pd_out, 8'hA3)
    `CHK(pc_oe, 2'h1)
    `CHK(pc_out, 2'h1)
    wr(12'h080, 8'h03);
    settle;
    `CHK(pd_oe, 8'hF0)
    `CHK(pd_out, 8'hC3)
    `CHK(clk_in, 1'b1)
    `CHK(int_in, 1'b0)
    rd(12'h01C, 32'h0F);
    settle;
    `CHK(idi_in, 8'hCC)
    wr(12'h080, 8'h00);
    settle;
    `CHK(pc_oe, 2'h3)
    `CHK(pd_oe, 8'h0F)
    `CHK(pd_out, 8'hA5)
    $display("test link ownership done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wr(12'h018, 8'h03);
    rd(12'h010, 32'h0);
    wr(12'h01C, 8'hFF);
    rd(12'h014, 32'h0);
    $display("test reset in mid-run done");
    test_done;
  end
endmodule
